// ==== pkg/mon_pkg.sv ====
// Shared constants and types for the monitor converter sequencer and interrupt logic.
package mon_pkg;

    // Converter channel and result geometry.
    localparam int NCH      = 8;
    localparam int CH_W     = 3;
    localparam int RES_W    = 16;
    localparam int SAMPLE_W = 2;
    localparam int THERM_W  = 3;
    localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;

    // Interrupt source positions in the live status vector.
    localparam int NSRC         = 8;
    localparam int SRC_PG_ON    = 0;
    localparam int SRC_PG_OFF   = 1;
    localparam int SRC_ICL      = 2;
    localparam int SRC_VCL      = 3;
    localparam int SRC_WDOG     = 4;
    localparam int SRC_THERM    = 5;
    localparam int SRC_THERMAL_SHUTDOWN_EVENT    = 6;
    localparam int SRC_DONE     = 7;

    // Live status after reset: supply not good, so the removed source reads high.
    localparam logic [NSRC-1:0] IRQ_STAT_RST = 8'h02;

    // Interrupt pulse width, as a time and as a count of clock cycles.
    localparam int CLK_MHZ       = 200;
    localparam int INT_PULSE_US  = 256;
    localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
    localparam int PULSE_W       = 16;

    // Sequencer states.
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_WAIT
    } seq_state_t;

endpackage

// ==== pkg/irq_bank_if.sv ====
// Carrier between the sequencer top and its sticky flag bank.
`timescale 1ns/1ps
interface irq_bank_if;
    import mon_pkg::*;

    logic [NSRC-1:0] status;
    logic [NSRC-1:0] mask;
    logic [NSRC-1:0] hold;
    logic            read;
    logic [NSRC-1:0] flags;
    logic [NSRC-1:0] rdata;
    logic            event_hit;

    modport ctl  (output status, mask, hold, read, input flags, rdata, event_hit);
    modport bank (input status, mask, hold, read, output flags, rdata, event_hit);
endinterface

// ==== core/irq_flag_bank.sv ====
// Edge detection, sticky clear-on-read flags and masked event generation.
`timescale 1ns/1ps
module irq_flag_bank
    import mon_pkg::*;
(
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic srst,
    // Link to the sequencer top.
    irq_bank_if.bank  b
);

    logic [NSRC-1:0] prev_ff;
    logic [NSRC-1:0] flag_ff;
    logic [NSRC-1:0] rdata_ff;
    logic            event_ff;
    logic [NSRC-1:0] rise;

    // Rising edges of the live status bits.
    assign rise = b.status & ~prev_ff;

    // Previous status, reset to the status reset value so no edge appears at start.
    always_ff @(posedge mclk) begin
        if (srst) begin
            prev_ff <= IRQ_STAT_RST;
        end else begin
            prev_ff <= b.status;
        end
    end

    // One sticky flag per source; a new edge wins over a read in the same cycle.
    for (genvar i = 0; i < NSRC; i++) begin : g_flag
        always_ff @(posedge mclk) begin
            if (srst) begin
                flag_ff[i] <= 1'b0;
            end else if (rise[i]) begin
                flag_ff[i] <= 1'b1;
            end else if (b.read && !b.hold[i]) begin
                flag_ff[i] <= 1'b0;
            end
        end
    end

    // Snapshot of the flags returned to the host on a read.
    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_ff <= '0;
        end else if (b.read) begin
            rdata_ff <= flag_ff;
        end
    end

    // Masked sources never raise an event.
    always_ff @(posedge mclk) begin
        if (srst) begin
            event_ff <= 1'b0;
        end else begin
            event_ff <= |(rise & ~b.mask);
        end
    end

    assign b.flags     = flag_ff;
    assign b.rdata     = rdata_ff;
    assign b.event_hit = event_ff;

endmodule

// ==== core/monitor_adc_status_interrupt.sv ====
// Monitor converter sequencer, supply-good indicator and host interrupt pulse.
`timescale 1ns/1ps
module monitor_adc_status_interrupt
    import mon_pkg::*;
#(
    parameter int PULSE_CYC = INT_PULSE_CYC
)
(
    // Clock and reset.
    input  wire logic                mclk,
    input  wire logic                srst,
    // Supply-valid conditions.
    input  wire logic                in_supply_valid,
    input  wire logic                batt_supply_valid,
    // Converter control from software.
    input  wire logic                adc_run_wr,
    input  wire logic                adc_run_wdata,
    input  wire logic                rate_oneshot,
    input  wire logic [SAMPLE_W-1:0] sample_sel,
    input  wire logic [NCH-1:0]      chan_disable,
    output logic                     adc_run,
    // Analog converter handshake.
    output logic                     conv_start,
    output logic [CH_W-1:0]          conv_chan,
    output logic [SAMPLE_W-1:0]      conv_sample,
    input  wire logic                conv_valid,
    input  wire logic [RES_W-1:0]    conv_data,
    // Result read port.
    input  wire logic [CH_W-1:0]     result_sel,
    output logic [RES_W-1:0]         result_data,
    // Supply-good indicator.
    input  wire logic                input_in_window,
    input  wire logic                input_under_comparator,
    input  wire logic                input_over_comparator,
    input  wire logic                power_stage_off_mode,
    input  wire logic                supply_good_pin_detach,
    input  wire logic                indicator_force_low,
    output logic                     supply_good_live,
    output logic                     supply_good_pin_n,
    // Interrupt sources, masks and flags.
    input  wire logic                input_current_limit,
    input  wire logic                input_voltage_limit,
    input  wire logic                watchdog_expired,
    input  wire logic [THERM_W-1:0]  thermistor_state,
    input  wire logic                thermal_shutdown_event,
    input  wire logic [NSRC-1:0]     irq_mask,
    input  wire logic                flag_read,
    output logic [NSRC-1:0]          irq_status,
    output logic [NSRC-1:0]          irq_flags,
    output logic [NSRC-1:0]          flag_rdata,
    output logic                     int_pin_n
);

    localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(PULSE_CYC);

    seq_state_t            state_ff;
    logic                  run_ff;
    logic                  start_ff;
    logic [CH_W-1:0]       chan_ff;
    logic [SAMPLE_W-1:0]   sample_ff;
    logic                  done_stat_ff;
    logic [RES_W-1:0]      res_mem [NCH];
    logic [RES_W-1:0]      result_ff;
    logic                  good_ff;
    logic                  pin_n_ff;
    logic [THERM_W-1:0]    therm_prev_ff;
    logic [NSRC-1:0]       status_ff;
    logic [PULSE_W-1:0]    pulse_cnt_ff;
    logic                  int_n_ff;

    logic                  seq_go;
    logic                  all_off;
    logic [CH_W:0]         first_hit;
    logic [CH_W:0]         next_hit;
    logic                  meas_done;
    logic                  cycle_end;

    irq_bank_if ifc ();

    // Lowest enabled channel at or above a start index; top bit flags a hit.
    function automatic logic [CH_W:0] find_ch(input logic [NCH-1:0] dis,
                                              input logic [CH_W:0]  from);
        logic [CH_W:0] r;
        r = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (!dis[i] && (i >= int'(from))) begin
                r = {1'b1, CH_W'(i)};
            end
        end
        return r;
    endfunction

    // Sequencing conditions derived from the run bit, supplies and channel mask.
    assign seq_go    = run_ff && (in_supply_valid || batt_supply_valid);
    assign all_off   = &chan_disable;
    assign first_hit = find_ch(chan_disable, '0);
    assign next_hit  = find_ch(chan_disable, {1'b0, chan_ff} + (CH_W+1)'(1));
    assign meas_done = (state_ff == SEQ_WAIT) && seq_go && conv_valid;
    assign cycle_end = meas_done && !next_hit[CH_W];

    // Run bit: software writes win; in one-shot mode only, hardware clears it at cycle end or all-off.
    always_ff @(posedge mclk) begin
        if (srst) begin
            run_ff <= 1'b0;
        end else if (adc_run_wr) begin
            run_ff <= adc_run_wdata;
        end else if (run_ff && rate_oneshot && cycle_end) begin
            run_ff <= 1'b0;
        end else if (run_ff && rate_oneshot && all_off && state_ff != SEQ_WAIT) begin
            run_ff <= 1'b0;
        end
    end

    // Channel walk: start a measurement, wait for it, move to the next channel.
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_ff <= SEQ_IDLE;
            start_ff <= 1'b0;
            chan_ff  <= '0;
        end else begin
            start_ff <= 1'b0;
            unique case (state_ff)
                SEQ_IDLE: begin
                    if (seq_go && first_hit[CH_W]) begin
                        chan_ff  <= first_hit[CH_W-1:0];
                        start_ff <= 1'b1;
                        state_ff <= SEQ_WAIT;
                    end
                end
                SEQ_WAIT: begin
                    if (!seq_go) begin
                        state_ff <= SEQ_IDLE;
                    end else if (conv_valid) begin
                        if (next_hit[CH_W]) begin
                            chan_ff  <= next_hit[CH_W-1:0];
                            start_ff <= 1'b1;
                        end else if (!rate_oneshot && first_hit[CH_W]) begin
                            chan_ff  <= first_hit[CH_W-1:0];
                            start_ff <= 1'b1;
                        end else begin
                            state_ff <= SEQ_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Sample field is handed to the converter from a register.
    always_ff @(posedge mclk) begin
        if (srst) begin
            sample_ff <= '0;
        end else begin
            sample_ff <= sample_sel;
        end
    end

    // Result store: only finished measurements overwrite, others keep old values.
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < NCH; i++) begin
                res_mem[i] <= RESULT_RST;
            end
        end else if (meas_done) begin
            res_mem[chan_ff] <= conv_data;
        end
    end

    // Registered result read port.
    always_ff @(posedge mclk) begin
        if (srst) begin
            result_ff <= RESULT_RST;
        end else begin
            result_ff <= res_mem[result_sel];
        end
    end

    // Done status: set at one-shot end, zero in continuous, cleared on a new start.
    always_ff @(posedge mclk) begin
        if (srst) begin
            done_stat_ff <= 1'b0;
        end else if (!rate_oneshot) begin
            done_stat_ff <= 1'b0;
        end else if (adc_run_wr && adc_run_wdata) begin
            done_stat_ff <= 1'b0;
        end else if (run_ff && cycle_end) begin
            done_stat_ff <= 1'b1;
        end
    end

    // Supply-good status and the active-low indicator pin.
    always_ff @(posedge mclk) begin
        if (srst) begin
            good_ff  <= 1'b0;
            pin_n_ff <= 1'b1;
        end else begin
            good_ff <= input_in_window && input_under_comparator
                       && input_over_comparator && !power_stage_off_mode;
            if (supply_good_pin_detach) begin
                pin_n_ff <= !indicator_force_low;
            end else begin
                pin_n_ff <= !good_ff;
            end
        end
    end

    // Previous thermistor state, used to see any change of state.
    always_ff @(posedge mclk) begin
        if (srst) begin
            therm_prev_ff <= '0;
        end else begin
            therm_prev_ff <= thermistor_state;
        end
    end

    // Live status of every interrupt source.
    always_ff @(posedge mclk) begin
        if (srst) begin
            status_ff <= IRQ_STAT_RST;
        end else begin
            status_ff[SRC_PG_ON]  <= good_ff;
            status_ff[SRC_PG_OFF] <= !good_ff;
            status_ff[SRC_ICL]    <= input_current_limit;
            status_ff[SRC_VCL]    <= input_voltage_limit;
            status_ff[SRC_WDOG]   <= watchdog_expired;
            status_ff[SRC_THERM]  <= thermistor_state != therm_prev_ff;
            status_ff[SRC_THERMAL_SHUTDOWN_EVENT]  <= thermal_shutdown_event;
            status_ff[SRC_DONE]   <= done_stat_ff;
        end
    end

    // Hand the status, masks and read strobe to the flag bank.
    always_comb begin
        ifc.status         = status_ff;
        ifc.mask           = irq_mask;
        ifc.read           = flag_read;
        ifc.hold           = '0;
        ifc.hold[SRC_DONE] = !rate_oneshot;
    end

    irq_flag_bank u_flags (
        .mclk (mclk),
        .srst (srst),
        .b    (ifc.bank)
    );

    // Interrupt pulse: one fixed-width low pulse; events during it are merged.
    always_ff @(posedge mclk) begin
        if (srst) begin
            pulse_cnt_ff <= '0;
            int_n_ff     <= 1'b1;
        end else if (pulse_cnt_ff != '0) begin
            pulse_cnt_ff <= pulse_cnt_ff - PULSE_W'(1);
            if (pulse_cnt_ff == PULSE_W'(1)) begin
                int_n_ff <= 1'b1;
            end
        end else if (ifc.event_hit) begin
            pulse_cnt_ff <= PULSE_LOAD;
            int_n_ff     <= 1'b0;
        end
    end

    // Outputs straight from their registers.
    assign adc_run           = run_ff;
    assign conv_start        = start_ff;
    assign conv_chan         = chan_ff;
    assign conv_sample       = sample_ff;
    assign result_data       = result_ff;
    assign supply_good_live  = good_ff;
    assign supply_good_pin_n = pin_n_ff;
    assign irq_status        = status_ff;
    assign irq_flags         = ifc.flags;
    assign flag_rdata        = ifc.rdata;
    assign int_pin_n         = int_n_ff;

endmodule

// ==== bench/mon_adc_model.sv ====
// Behavioural model of the analog converter that answers the latest measurement start.
`timescale 1ns/1ps
module mon_adc_model
    import mon_pkg::*;
(
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             srst,
    // Start request and answer speed.
    input  wire logic             conv_start,
    input  wire logic [CH_W-1:0]  conv_chan,
    input  wire logic             slow,
    // Measurement result.
    output logic                  conv_valid,
    output logic [RES_W-1:0]      conv_data
);
    int cnt;

    // A fresh start restarts the count, so an aborted measurement is simply overtaken.
    // Outside the valid cycle the data bus toggles, so stale data is never mistaken for good.
    always_ff @(posedge mclk) begin
        conv_valid <= 1'b0;
        conv_data  <= ~conv_data;
        if (srst) begin
            cnt       <= 0;
            conv_data <= 16'h5AA5;
        end else if (conv_start) begin
            cnt <= slow ? 12 : 2;
        end else if (cnt == 1) begin
            conv_valid <= 1'b1;
            conv_data  <= {5'h15, conv_chan, 8'h3C};
            cnt        <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ==== bench/monitor_adc_status_interrupt_chk.sv ====
// Port-level assertions for the sequencer, supply-good indicator and interrupt pulse.
`timescale 1ns/1ps
module mon_irq_chk
    import mon_pkg::*;
#(
    parameter int PULSE_CYC = 16
)
(
    // Clock and reset.
    input  wire logic            mclk,
    input  wire logic            srst,
    // Converter control.
    input  wire logic            in_supply_valid,
    input  wire logic            batt_supply_valid,
    input  wire logic            adc_run_wr,
    input  wire logic            adc_run_wdata,
    input  wire logic            rate_oneshot,
    input  wire logic            adc_run,
    input  wire logic            conv_start,
    // Supply-good indicator.
    input  wire logic            supply_good_pin_detach,
    input  wire logic            indicator_force_low,
    input  wire logic            supply_good_live,
    input  wire logic            supply_good_pin_n,
    // Interrupts.
    input  wire logic [NSRC-1:0] irq_mask,
    input  wire logic            flag_read,
    input  wire logic [NSRC-1:0] irq_status,
    input  wire logic [NSRC-1:0] irq_flags,
    input  wire logic            int_pin_n
);
    logic [NSRC-1:0]    prev_stat_ff;
    logic [NSRC-1:0]    rise;
    logic [PULSE_W-1:0] low_cnt_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    // Remembers the last live status so that new rises can be seen.
    always_ff @(posedge mclk) begin
        prev_stat_ff <= srst ? IRQ_STAT_RST : irq_status;
    end
    assign rise = irq_status & ~prev_stat_ff;

    // Counts the low cycles of the present interrupt pulse.
    always_ff @(posedge mclk) begin
        low_cnt_ff <= (srst || int_pin_n) ? 16'h0000 : low_cnt_ff + 16'h0001;
    end

    chk_pulse_width: assert property (
        int_pin_n && low_cnt_ff != 16'h0000 |-> int'(low_cnt_ff) == PULSE_CYC)
        else $error("interrupt pulse has the wrong width");
    chk_pulse_launch: assert property (
        (rise & ~irq_mask) != 8'h00 && int_pin_n && low_cnt_ff == 16'h0000
        |-> ##[1:3] !int_pin_n)
        else $error("unmasked status rise gave no pulse");
    chk_flag_set: assert property (
        rise != 8'h00 |=> (irq_flags & $past(rise)) == $past(rise))
        else $error("status rise did not set its flag");
    chk_read_clear: assert property (
        flag_read |=> (irq_flags & 8'h7F & ~rise & ~$past(rise)) == 8'h00)
        else $error("flags not cleared by a read");
    chk_pin_follow: assert property (
        !supply_good_pin_detach && !$past(supply_good_pin_detach) && !$past(srst)
        |-> supply_good_pin_n == !$past(supply_good_live))
        else $error("indicator pin does not follow supply good");
    chk_pin_forced: assert property (
        supply_good_pin_detach && $past(supply_good_pin_detach) && !$past(srst)
        |-> supply_good_pin_n == !$past(indicator_force_low))
        else $error("detached indicator pin ignores the force bit");
    chk_start_gate: assert property (
        conv_start |-> $past(adc_run) && $past(in_supply_valid || batt_supply_valid))
        else $error("measurement started without run or supply");
    chk_stop_now: assert property (
        adc_run_wr && !adc_run_wdata |=> !adc_run ##1 !conv_start [*4])
        else $error("converter kept running after stop");
    chk_done_quiet: assert property (
        !rate_oneshot [*3] |-> !irq_status[SRC_DONE]
        && irq_flags[SRC_DONE] == $past(irq_flags[SRC_DONE]))
        else $error("done bits moved in continuous mode");
    chk_oneshot_end: assert property (
        $rose(irq_status[SRC_DONE]) |-> !adc_run && !$past(adc_run))
        else $error("done reported while the run bit stays set");

    cover property (!int_pin_n [*2]);
    cover property ($rose(irq_status[SRC_DONE]));
    cover property (supply_good_pin_detach && !supply_good_pin_n);
endmodule

bind monitor_adc_status_interrupt mon_irq_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (
    .mclk(mclk), .srst(srst), .in_supply_valid(in_supply_valid),
    .batt_supply_valid(batt_supply_valid), .adc_run_wr(adc_run_wr), .adc_run_wdata(adc_run_wdata),
    .rate_oneshot(rate_oneshot), .adc_run(adc_run), .conv_start(conv_start),
    .supply_good_pin_detach(supply_good_pin_detach), .indicator_force_low(indicator_force_low),
    .supply_good_live(supply_good_live), .supply_good_pin_n(supply_good_pin_n),
    .irq_mask(irq_mask), .flag_read(flag_read), .irq_status(irq_status),
    .irq_flags(irq_flags), .int_pin_n(int_pin_n));

// ==== bench/monitor_adc_status_interrupt_test.sv ====
// Self-checking bench for the converter sequencer, indicator and interrupt block.
`timescale 1ns/1ps
module monitor_adc_status_interrupt_test
    import mon_pkg::*;
;
    localparam int PC = 16;
    logic mclk = 1'b0, srst = 1'b1, in_supply_valid = 1'b1, batt_supply_valid = 1'b0;
    logic adc_run_wr = 1'b0, adc_run_wdata = 1'b0, rate_oneshot = 1'b1, slow = 1'b0;
    logic supply_good_pin_detach = 1'b0, indicator_force_low = 1'b0, flag_read = 1'b0;
    logic [SAMPLE_W-1:0] sample_sel = 2'h2, conv_sample;
    logic [NCH-1:0]      chan_disable = 8'h00;
    logic [NSRC-1:0]     irq_mask = 8'h00, src_v = 8'h00, irq_status, irq_flags, flag_rdata, f;
    logic [3:0]          good_v = 4'h0;
    logic [CH_W-1:0]     result_sel = 3'h0, conv_chan;
    logic [RES_W-1:0]    conv_data, result_data;
    logic adc_run, conv_start, conv_valid, supply_good_live, supply_good_pin_n, int_pin_n;
    int n_fail = 0, num_checks = 0, n_start = 0, k, s0;

    // Clock of 5 ns period.
    always #2.5 mclk = ~mclk;

    // Counts measurement starts seen at the converter port.
    always @(posedge mclk) if (conv_start === 1'b1) n_start <= n_start + 1;

    monitor_adc_status_interrupt #(.PULSE_CYC(PC)) DUT (
        .mclk(mclk), .srst(srst), .in_supply_valid(in_supply_valid),
        .batt_supply_valid(batt_supply_valid), .adc_run_wr(adc_run_wr),
        .adc_run_wdata(adc_run_wdata), .rate_oneshot(rate_oneshot), .sample_sel(sample_sel),
        .chan_disable(chan_disable), .adc_run(adc_run), .conv_start(conv_start),
        .conv_chan(conv_chan), .conv_sample(conv_sample), .conv_valid(conv_valid),
        .conv_data(conv_data), .result_sel(result_sel), .result_data(result_data),
        .input_in_window(good_v[3]), .input_under_comparator(good_v[2]),
        .input_over_comparator(good_v[1]), .power_stage_off_mode(~good_v[0]),
        .supply_good_pin_detach(supply_good_pin_detach), .indicator_force_low(indicator_force_low),
        .supply_good_live(supply_good_live), .supply_good_pin_n(supply_good_pin_n),
        .input_current_limit(src_v[2]), .input_voltage_limit(src_v[3]),
        .watchdog_expired(src_v[4]), .thermistor_state({2'b00, src_v[5]}),
        .thermal_shutdown_event(src_v[6]), .irq_mask(irq_mask), .flag_read(flag_read),
        .irq_status(irq_status), .irq_flags(irq_flags), .flag_rdata(flag_rdata),
        .int_pin_n(int_pin_n));

    mon_adc_model u_adc (.mclk(mclk), .srst(srst), .conv_start(conv_start),
        .conv_chan(conv_chan), .slow(slow), .conv_valid(conv_valid), .conv_data(conv_data));

    // Compares one value and counts the outcome.
    task automatic check(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Software write of the run bit, one cycle wide.
    task automatic run_write(input logic v);
        adc_run_wr = 1'b1;
        adc_run_wdata = v;
        tick(1);
        adc_run_wr = 1'b0;
    endtask

    // Host read of the sticky flags.
    task automatic read_flags();
        flag_read = 1'b1;
        tick(1);
        flag_read = 0;
        tick(1);
        f = flag_rdata;
    endtask

    task automatic res(input logic [CH_W-1:0] ch, input logic [RES_W-1:0] exp);
        result_sel = ch;
        tick(2);
        check(result_data, exp);
    endtask

    // Bounded wait: 0 run bit low, 1 start on channel 1, 2 interrupt pin low.
    task automatic wait_for(input int sel);
        k = 0;
        while (!(sel == 0 ? adc_run === 1'b0 : sel == 1 ? (conv_start === 1'b1 &&
                conv_chan === 3'h1) : int_pin_n === 1'b0) && k < 500) begin
            tick(1);
            k++;
        end
        if (k == 500) begin
            n_fail++;
            wrap_up();
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Cuts a hung run short.
    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end

    // Main sequence.
    initial begin
        tick(10);
        srst = 1'b0;
        tick(1);
        check(irq_status, IRQ_STAT_RST);
        check(int_pin_n, 1'b1);
        res(3'h0, RESULT_RST);
        for (int i = 0; i < 5; i++) begin
            good_v = 4'hF ^ (4'h1 << i);
            tick(3);
            check(supply_good_live, i == 4);
            check(supply_good_pin_n, i != 4);
        end
        supply_good_pin_detach = 1'b1;
        for (int i = 0; i < 2; i++) begin
            indicator_force_low = i[0];
            tick(2);
            check(supply_good_pin_n, !i[0]);
        end
        supply_good_pin_detach = 1'b0;
        tick(PC + 8);
        read_flags();
        read_flags();
        check(f, 8'h00);
        good_v = 4'h7;
        wait_for(2);
        s0 = 0;
        while (int_pin_n === 1'b0 && s0 < 4 * PC) begin
            if (s0 == 4) src_v[2] = 1'b1;
            tick(1);
            s0++;
        end
        check(s0, PC);
        tick(6);
        check(int_pin_n, 1'b1);
        check(irq_status[2], 1'b1);
        read_flags();
        check(f, 8'h06);
        for (int i = 3; i < 7; i++) begin
            irq_mask = (i == 3) ? 8'h08 : 8'h00;
            src_v[i] = 1'b1;
            s0 = 0;
            repeat (6) begin
                tick(1);
                if (int_pin_n === 1'b0) s0 = 1;
            end
            check(s0, i != 3);
            tick(PC);
            read_flags();
            check(f, 8'h01 << i);
        end
        irq_mask = 8'hFF;
        chan_disable = 8'hF5;
        s0 = n_start;
        run_write(1'b1);
        wait_for(0);
        tick(4);
        check(n_start - s0, 2);
        check(conv_sample, 2'h2);
        check(irq_status[7], 1'b1);
        check(irq_flags[7], 1'b1);
        check(int_pin_n, 1'b1);
        res(3'h3, {5'h15, 3'h3, 8'h3C});
        res(3'h0, RESULT_RST);
        rate_oneshot = 1'b0;
        chan_disable = 8'hF0;
        slow = 1'b1;
        s0 = n_start;
        run_write(1'b1);
        tick(130);
        check((n_start - s0) > 4, 1'b1);
        check(irq_status[7], 1'b0);
        read_flags();
        check(f[7], 1'b1);
        check(irq_flags[7], 1'b1);
        wait_for(1);
        chan_disable = 8'hF2;
        rate_oneshot = 1'b1;
        s0 = n_start + 1;
        wait_for(0);
        tick(4);
        check(n_start - s0, 2);
        rate_oneshot = 1'b0;
        chan_disable = 8'hFE;
        run_write(1'b1);
        tick(4);
        run_write(1'b0);
        s0 = n_start;
        tick(30);
        check(adc_run, 1'b0);
        check(n_start - s0, 0);
        rate_oneshot = 1'b1;
        chan_disable = 8'hFF;
        run_write(1'b1);
        tick(3);
        check(adc_run, 1'b0);
        in_supply_valid = 1'b0;
        irq_mask = 8'h7F;
        chan_disable = 8'h7F;
        slow = 1'b0;
        s0 = n_start;
        run_write(1'b1);
        tick(20);
        check(n_start - s0, 0);
        check(adc_run, 1'b1);
        batt_supply_valid = 1'b1;
        wait_for(0);
        tick(4);
        check(int_pin_n, 1'b0);
        res(3'h7, {5'h15, 3'h7, 8'h3C});
        wrap_up();
    end
endmodule
